// >>> buckboost_sequencer.sv
// Mode sequencer and protection state machines of the buck-boost converter.
// Assumes enables and comparator results arrive asynchronously from pins
// and analog circuits; switch commands drive external gate drivers.
//
// What this block does
// - Soft-start ramps reference within 500 us
// - Ramp done enables both protections together
// - Normal operation keeps both protections enabled
// - Buck: input pair switches, output high on
// - Boost: output pair switches, input high on
// - Within 0.5 V both pairs switch
// - Two 1.5 A hits raise limit to 4 A
// - 4 A mode lasts 50 us, then 1.5 A
// - No 1.5 A hit for 5 us: normal
// - Recurring hit restarts the 5 us count
// - All intervals counted on switching oscillator
// - Output at or under 80% starts monitoring
// - Monitor 0.5 ms then 8 ms zero hold
// - After hold, soft-start then normal or monitor
// - Hiccup repeats until output recovers or an enable drops
// - Oscillator runs at 1.5 MHz
// - Idle waits 50 us, protections off
// - Run only when all four enables high
// - Disable resets sequencer and protections
`timescale 1ns/10ps
module buckboost_sequencer #(
  parameter int IDLE_COUNT = buckboost_pkg::IDLE_TICKS,
  parameter int RAMP_COUNT = buckboost_pkg::RAMP_TICKS,
  parameter int CL4_COUNT = buckboost_pkg::CL4_TICKS,
  parameter int MON_COUNT = buckboost_pkg::MON_TICKS,
  parameter int HOLD_COUNT = buckboost_pkg::HOLD_TICKS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire buckboost_pkg::enable_s enables,
  input wire buckboost_pkg::sense_s sense,
  output buckboost_pkg::gates_s gates,
  output buckboost_pkg::status_s status
);
  import buckboost_pkg::*;

  enable_s enables_meta;
  enable_s enables_sync;
  sense_s sense_meta;
  sense_s sense_sync;
  logic tick;
  logic phase;
  logic run;
  logic ss_done;
  logic guards_on;
  seq_state_e state;
  cl_state_e cl_state;
  conv_mode_e conv_mode;
  logic [TIMER_W-1:0] timer;
  logic [RAMP_W-1:0] ramp;
  logic [CL_W-1:0] cl_timer;
  logic [1:0] hits;

  // One switch pair: switching follows the oscillator phase, else static
  function automatic logic [1:0] pair_drive(input logic switching,
                                            input logic ph);
    if (switching) begin
      pair_drive = {ph, ~ph};
    end else begin
      pair_drive = 2'b10;
    end
  endfunction

  // Two-stage synchronisers for pins and comparators
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      enables_meta <= '0;
      enables_sync <= '0;
      sense_meta <= '0;
      sense_sync <= '0;
    end else begin
      enables_meta <= enables;
      enables_sync <= enables_meta;
      sense_meta <= sense;
      sense_sync <= sense_meta;
    end
  end

  // Switching oscillator times every interval
  switching_oscillator osc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(tick),
    .phase(phase)
  );

  assign run = &enables_sync;
  assign ss_done = (ramp == RAMP_W'(RAMP_COUNT));
  assign guards_on = (state == SEQ_NORMAL) || (state == SEQ_MONITOR);

  // Converter mode from supply versus output comparisons
  always_comb begin
    if (sense_sync.supply_output_close) begin
      conv_mode = CONV_BUCK_BOOST;
    end else if (sense_sync.supply_above_output) begin
      conv_mode = CONV_BUCK;
    end else begin
      conv_mode = CONV_BOOST;
    end
  end

  // Power-up sequence and short-circuit hiccup
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      state <= SEQ_DISABLED;
      timer <= '0;
      ramp <= '0;
    end else begin
      case (state)
        SEQ_DISABLED: begin
          state <= SEQ_IDLE;
          timer <= '0;
        end
        SEQ_IDLE: begin
          if (tick) begin
            if (timer == TIMER_W'(IDLE_COUNT - 1)) begin
              state <= SEQ_SOFTSTART;
              timer <= '0;
              ramp <= '0;
            end else begin
              timer <= timer + 1'b1;
            end
          end
        end
        SEQ_SOFTSTART: begin
          if (ss_done) begin
            timer <= '0;
            if (sense_sync.output_above_80pct) begin
              state <= SEQ_NORMAL;
            end else begin
              state <= SEQ_MONITOR;
            end
          end else if (tick) begin
            ramp <= ramp + 1'b1;
          end
        end
        SEQ_NORMAL: begin
          if (!sense_sync.output_above_80pct) begin
            state <= SEQ_MONITOR;
            timer <= '0;
          end
        end
        SEQ_MONITOR: begin
          if (sense_sync.output_above_target) begin
            state <= SEQ_NORMAL;
            timer <= '0;
          end else if (tick) begin
            if (timer == TIMER_W'(MON_COUNT - 1)) begin
              state <= SEQ_HOLD;
              timer <= '0;
            end else begin
              timer <= timer + 1'b1;
            end
          end
        end
        SEQ_HOLD: begin
          if (tick) begin
            if (timer == TIMER_W'(HOLD_COUNT - 1)) begin
              state <= SEQ_SOFTSTART;
              timer <= '0;
              ramp <= '0;
            end else begin
              timer <= timer + 1'b1;
            end
          end
        end
        default: begin
          state <= SEQ_DISABLED;
          timer <= '0;
          ramp <= '0;
        end
      endcase
    end
  end

  // Current-limit detection modes, run only while guards are on
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !guards_on) begin
      cl_state <= CL_NORMAL;
      cl_timer <= '0;
      hits <= '0;
    end else if (tick) begin
      case (cl_state)
        CL_NORMAL: begin
          if (!sense_sync.peak_over_1p5a) begin
            hits <= '0;
          end else if (hits == HITS_TO_4A - 2'h1) begin
            cl_state <= CL_DETECT_4A;
            cl_timer <= '0;
            hits <= '0;
          end else begin
            hits <= hits + 1'b1;
          end
        end
        CL_DETECT_4A: begin
          if (cl_timer == CL_W'(CL4_COUNT - 1)) begin
            cl_state <= CL_DETECT_1P5A;
            cl_timer <= '0;
          end else begin
            cl_timer <= cl_timer + 1'b1;
          end
        end
        CL_DETECT_1P5A: begin
          if (sense_sync.peak_over_1p5a) begin
            cl_timer <= '0;
          end else if (cl_timer == CL_W'(CL15_TICKS - 1)) begin
            cl_state <= CL_NORMAL;
            cl_timer <= '0;
          end else begin
            cl_timer <= cl_timer + 1'b1;
          end
        end
        default: begin
          cl_state <= CL_NORMAL;
          cl_timer <= '0;
          hits <= '0;
        end
      endcase
    end
  end

  // Switch gate commands per sequencer state and converter mode
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gates <= '0;
    end else begin
      case (state)
        SEQ_DISABLED, SEQ_HOLD: begin
          gates <= 4'h6; // Discharge: input low and output high on
        end
        SEQ_IDLE: begin
          gates <= '0;
        end
        default: begin
          gates[3:2] <= pair_drive(conv_mode != CONV_BOOST, phase);
          gates[1:0] <= pair_drive(conv_mode != CONV_BUCK, phase);
        end
      endcase
    end
  end

  // Registered status, guards enabled together after soft-start
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status <= '0;
    end else begin
      status.seq_state <= state;
      status.cl_state <= cl_state;
      status.conv_mode <= conv_mode;
      status.current_limit_guard <= guards_on;
      status.short_circuit_guard <= guards_on;
      status.limit_4a <= (cl_state == CL_DETECT_4A);
      status.ss_done <= ss_done;
      status.ss_ref <= ramp;
    end
  end

endmodule

// >>> buckboost_pkg.sv
// Constants, states and carriers for the buck-boost mode sequencer.
// Assumes a 100 MHz system clock and a 1.5 MHz switching oscillator.
package buckboost_pkg;

  // System clock and switching oscillator rates
  localparam int CLK_KHZ = 100000;
  localparam int OSC_KHZ = 1500;
  localparam int OSC_DIV = (CLK_KHZ + OSC_KHZ / 2) / OSC_KHZ;
  localparam int OSC_CNT_W = 7;

  // Printed times, each in its own unit
  localparam int IDLE_US = 50;
  localparam int RAMP_US = 500;
  localparam int CL4_US = 50;
  localparam int CL15_US = 5;
  localparam int MON_US = 500;
  localparam int HOLD_MS = 8;

  // Oscillator tick counts; least times round up, the ramp bound down
  localparam int IDLE_TICKS = (IDLE_US * OSC_KHZ + 999) / 1000;
  localparam int RAMP_TICKS = (RAMP_US * OSC_KHZ) / 1000;
  localparam int CL4_TICKS = (CL4_US * OSC_KHZ + 999) / 1000;
  localparam int CL15_TICKS = (CL15_US * OSC_KHZ + 999) / 1000;
  localparam int MON_TICKS = (MON_US * OSC_KHZ + 999) / 1000;
  localparam int HOLD_TICKS = HOLD_MS * OSC_KHZ;

  // Counter widths and fixed values
  localparam int TIMER_W = 14;
  localparam int RAMP_W = 10;
  localparam int CL_W = 7;
  localparam logic [1:0] HITS_TO_4A = 2'h2;

  typedef enum logic [2:0] {
    SEQ_DISABLED,
    SEQ_IDLE,
    SEQ_SOFTSTART,
    SEQ_NORMAL,
    SEQ_MONITOR,
    SEQ_HOLD
  } seq_state_e;

  typedef enum logic [1:0] {
    CL_NORMAL,
    CL_DETECT_4A,
    CL_DETECT_1P5A
  } cl_state_e;

  typedef enum logic [1:0] {
    CONV_BUCK,
    CONV_BOOST,
    CONV_BUCK_BOOST
  } conv_mode_e;

  // Enable conditions, all must be high to run
  typedef struct packed {
    logic master_enable;
    logic io_supply_present;
    logic transmit_fast_enable_pin;
    logic converter_enable_bit;
  } enable_s;

  // Analog comparator results
  typedef struct packed {
    logic supply_above_output;
    logic supply_output_close;
    logic peak_over_1p5a;
    logic output_above_80pct;
    logic output_above_target;
  } sense_s;

  // Power switch gate commands, high means switch on
  typedef struct packed {
    logic input_side_high_switch;
    logic input_side_low_switch;
    logic output_side_high_switch;
    logic output_side_low_switch;
  } gates_s;

  typedef struct packed {
    seq_state_e seq_state;
    cl_state_e cl_state;
    conv_mode_e conv_mode;
    logic current_limit_guard;
    logic short_circuit_guard;
    logic limit_4a;
    logic ss_done;
    logic [RAMP_W-1:0] ss_ref;
  } status_s;

endpackage

// >>> switching_oscillator.sv
// Internal switching oscillator derived from the system clock.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/10ps
module switching_oscillator (
  input wire logic clk_sys,
  input wire logic sys_rst,
  output logic tick,
  output logic phase
);
  import buckboost_pkg::*;

  logic [OSC_CNT_W-1:0] count;

  // Divide down to the switching rate; tick marks each period start
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= '0;
      tick <= 1'b0;
      phase <= 1'b0;
    end else begin
      tick <= (count == OSC_CNT_W'(OSC_DIV - 1));
      if (count == OSC_CNT_W'(OSC_DIV - 1)) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
      phase <= (count < OSC_CNT_W'(OSC_DIV / 2));
    end
  end

endmodule

// >>> buckboost_sva.sv
// Port checker for the buck-boost mode sequencer.
// Assumes the 67-cycle switching oscillator period.
`timescale 1ns/10ps
module buckboost_sva #(
  parameter int CL4_COUNT = 4,
  parameter int RAMP_COUNT = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire buckboost_pkg::enable_s enables,
  input wire buckboost_pkg::sense_s sense,
  input wire buckboost_pkg::gates_s gates,
  input wire buckboost_pkg::status_s status
);
  import buckboost_pkg::*;
  localparam int P = OSC_DIV;
  localparam int C4_LO = (CL4_COUNT - 1) * P;
  localparam int C4_HI = (CL4_COUNT + 1) * P;
  localparam int SS_MAX = (RAMP_COUNT + 2) * P;
  seq_state_e st;
  logic [15:0] ss_cyc;
  logic [15:0] c4_cyc;
  assign st = status.seq_state;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Cycles spent in soft-start and in 4 A mode
  always_ff @(posedge clk_sys) begin
    ss_cyc <= (sys_rst || st != SEQ_SOFTSTART) ? '0 : ss_cyc + 16'h1;
    c4_cyc <= (sys_rst || status.cl_state != CL_DETECT_4A) ? '0 :
              c4_cyc + 16'h1;
  end
  guard_pair_a: assert property (
    status.current_limit_guard == status.short_circuit_guard &&
    status.short_circuit_guard == (st == SEQ_NORMAL || st == SEQ_MONITOR))
    else $error("guards differ");
  normal_guard_a: assert property (
    (st == SEQ_NORMAL) [*2] |-> status.current_limit_guard)
    else $error("guard off in normal");
  idle_guard_a: assert property (
    st == SEQ_IDLE |-> !status.short_circuit_guard)
    else $error("guard on in idle");
  disable_clear_a: assert property (
    (st == SEQ_DISABLED) [*2] |-> !status.current_limit_guard &&
    status.cl_state == CL_NORMAL && status.ss_ref == '0)
    else $error("disable not cleared");
  buck_gates_a: assert property (
    (st == SEQ_NORMAL && status.conv_mode == CONV_BUCK) [*2] |->
    gates[1:0] == 2'h2 && gates[3] != gates[2])
    else $error("buck gates wrong");
  boost_gates_a: assert property (
    (st == SEQ_NORMAL && status.conv_mode == CONV_BOOST) [*2] |->
    gates[3:2] == 2'h2 && gates[1] != gates[0])
    else $error("boost gates wrong");
  both_switch_a: assert property (
    (st == SEQ_NORMAL && status.conv_mode == CONV_BUCK_BOOST) [*2] |->
    gates[3] != gates[2] && gates[1] != gates[0])
    else $error("buck-boost gates wrong");
  hold_gates_a: assert property (
    (st == SEQ_HOLD) [*2] |-> gates == 4'h6)
    else $error("hold not discharging");
  low_out_a: assert property (
    not ((st == SEQ_NORMAL && !sense.output_above_80pct) [*6]))
    else $error("low output left in normal");
  limit_raise_a: assert property (
    (status.cl_state == CL_DETECT_4A) [*2] |-> status.limit_4a)
    else $error("limit not raised");
  cl4_time_a: assert property (
    status.cl_state == CL_DETECT_1P5A &&
    $past(status.cl_state) == CL_DETECT_4A |->
    c4_cyc >= C4_LO && c4_cyc <= C4_HI)
    else $error("4 A mode length wrong");
  ramp_bound_a: assert property (
    ss_cyc <= SS_MAX)
    else $error("soft-start too long");
endmodule
bind buckboost_sequencer buckboost_sva #(.CL4_COUNT(CL4_COUNT),
  .RAMP_COUNT(RAMP_COUNT)) u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .enables(enables), .sense(sense), .gates(gates), .status(status));

// >>> pa_load_model.sv
// Amplifier load and supply comparators at the converter output.
// Assumes the bench sets the fault knobs at the falling edge.
`timescale 1ns/10ps
module pa_load_model (
  input wire logic clk_sys,
  input wire buckboost_pkg::gates_s gates,
  input wire buckboost_pkg::status_s status,
  input wire logic short_req,
  input wire logic load_req,
  input wire logic [1:0] vin_sel,
  output buckboost_pkg::sense_s sense
);
  import buckboost_pkg::*;
  logic up;
  // Output rises after soft-start, stays low shorted or discharged
  always_ff @(posedge clk_sys) begin
    up <= !short_req && gates != 4'h6 &&
          (status.ss_done || status.short_circuit_guard);
  end
  // Comparator levels seen by the converter
  always_comb begin
    sense.supply_above_output = (vin_sel == 2'h0);
    sense.supply_output_close = (vin_sel == 2'h2);
    sense.peak_over_1p5a = load_req;
    sense.output_above_80pct = up;
    sense.output_above_target = up;
  end
endmodule

// >>> buckboost_sequencer_test.sv
// Self-checking bench for the buck-boost mode sequencer.
// Assumes small tick counts and a 67-cycle oscillator period.
`timescale 1ns/10ps
module buckboost_sequencer_test;
  import buckboost_pkg::*;
  localparam int P = OSC_DIV;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  enable_s enables = '0;
  logic short_req = 1'b0;
  logic load_req = 1'b0;
  logic [1:0] vin_sel = 2'h0;
  sense_s sense;
  gates_s gates;
  status_s status;
  int n_fail = 0;
  int n_compared = 0;
  int cyc;
  logic [31:0] il;
  logic [31:0] ol;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  n_fail++; $display("mismatch %0t %h %h", $time, a, b); end end
  // Free-running system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  buckboost_sequencer #(.IDLE_COUNT(3), .RAMP_COUNT(8), .CL4_COUNT(4),
    .MON_COUNT(5), .HOLD_COUNT(10)) DUT (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .enables(enables), .sense(sense),
    .gates(gates), .status(status));
  pa_load_model load (.clk_sys(clk_sys), .gates(gates), .status(status),
    .short_req(short_req), .load_req(load_req), .vin_sel(vin_sel),
    .sense(sense));
  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Bounded wait for a sequencer or limiter state
  task automatic wait_for(input bit w, input logic [2:0] v, input int max);
    cyc = 0;
    while ((w ? {1'b0, status.cl_state} : 3'(status.seq_state)) !== v) begin
      @(negedge clk_sys);
      cyc++;
      if (cyc > max) begin
        n_fail++;
        end_sim();
      end
    end
  endtask
  task automatic t_reset();
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      enables = ~(4'h1 << i);
      repeat (6) @(negedge clk_sys);
      `CHK(status.seq_state, SEQ_DISABLED)
    end
    `CHK(gates, 4'h6)
  endtask
  task automatic t_power_up();
    enables = 4'hF;
    wait_for(1'b0, SEQ_IDLE, 10);
    wait_for(1'b0, SEQ_SOFTSTART, 5 * P);
    `CHK(cyc >= 2 * P, 1'b1)
    wait_for(1'b0, SEQ_NORMAL, 20 * P);
    repeat (3) @(negedge clk_sys);
    `CHK(status.current_limit_guard, 1'b1)
    `CHK(status.ss_done, 1'b1)
    `CHK(status.ss_ref, 10'h008)
  endtask
  task automatic t_modes();
    for (int i = 0; i < 3; i++) begin
      vin_sel = 2'(i);
      repeat (2 * P) @(negedge clk_sys);
      il = '0;
      ol = '0;
      repeat (P) begin
        @(negedge clk_sys);
        il = il + 32'(gates.input_side_low_switch);
        ol = ol + 32'(gates.output_side_low_switch);
      end
      `CHK(status.conv_mode, conv_mode_e'(i))
      `CHK(il, (i == 1) ? 32'h0 : 32'h22)
      `CHK(ol, (i == 0) ? 32'h0 : 32'h22)
    end
    vin_sel = 2'h0;
  endtask
  task automatic t_current();
    load_req = 1'b1;
    wait_for(1'b1, CL_DETECT_4A, 4 * P);
    `CHK(cyc >= P, 1'b1)
    `CHK(status.limit_4a, 1'b1)
    wait_for(1'b1, CL_DETECT_1P5A, 6 * P);
    `CHK(cyc >= 3 * P, 1'b1)
    repeat (12 * P) @(negedge clk_sys);
    `CHK(status.cl_state, CL_DETECT_1P5A)
    load_req = 1'b0;
    wait_for(1'b1, CL_NORMAL, 11 * P);
    `CHK(cyc >= 7 * P, 1'b1)
  endtask
  task automatic t_short();
    short_req = 1'b1;
    wait_for(1'b0, SEQ_MONITOR, 10);
    wait_for(1'b0, SEQ_HOLD, 7 * P);
    `CHK(cyc >= 4 * P, 1'b1)
    wait_for(1'b0, SEQ_SOFTSTART, 12 * P);
    `CHK(cyc >= 9 * P, 1'b1)
    wait_for(1'b0, SEQ_MONITOR, 12 * P);
    short_req = 1'b0;
    wait_for(1'b0, SEQ_NORMAL, 8 * P);
    enables = 4'h7;
    repeat (6) @(negedge clk_sys);
    `CHK(status.seq_state, SEQ_DISABLED)
    `CHK(status.current_limit_guard, 1'b0)
  endtask
  // Main sequence
  initial begin
    t_reset();
    t_power_up();
    t_modes();
    t_current();
    t_short();
    end_sim();
  end
endmodule
